/* File: hw/chan_ready.sv */
// DMA ready output of channel A
`timescale 1ns/100ps
`include "serial_ctrl_defines.svh"
module chan_ready (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Ready field and buffer state
  input wire logic [2:0] i_ctrl,
  input wire logic i_tx_empty,
  input wire logic i_rx_avail,
  // DMA request, active low
  output logic o_ready_n
);
  import serial_ctrl_pkg::*;

  ready_state_type s_q, s_d;

  // Wait function is not wired here, so it idles high
  always_comb begin
    s_d = s_q;
    s_d.ready_n = ~(i_ctrl[`RDY_EN] & i_ctrl[`RDY_FUNC] &
      (i_ctrl[`RDY_ONRX] ? i_rx_avail : i_tx_empty));
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q.ready_n <= `READY_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ready_n = s_q.ready_n;
endmodule

/* File: hw/irq_arbiter.sv */
// Interrupt priority pick, in-service tracking and vector build
`timescale 1ns/100ps
`include "serial_ctrl_defines.svh"
module irq_arbiter (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Requests and acknowledge
  irq_if.arb irq
);
  import serial_ctrl_pkg::*;

  arb_state_type s_q, s_d;
  logic [2:0] top_code;
  logic [7:0] coded;

  // Highest code wins, so channel A outranks channel B
  always_comb begin
    top_code = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (irq.req[i]) begin
        top_code = 3'(i);
      end
    end
    coded = irq.base;
    coded[`VEC_CODE] = top_code;
  end

  // Only one level in service; no nesting
  always_comb begin
    s_d = s_q;
    if (irq.rti || irq.clear) begin
      s_d.in_service = 1'b0;
    end
    if (!s_d.in_service) begin
      s_d.vector = irq.base;
    end
    if (irq.inta && (|irq.req) && !s_d.in_service) begin
      s_d.in_service = 1'b1;
      s_d.vector = irq.sav ? coded : irq.base;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
      s_q.vector <= `VBASE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Request held off while a routine is in service
  assign irq.irq_out = (|irq.req) & ~s_q.in_service;
  assign irq.vector = s_q.vector;
endmodule

/* File: hw/irq_if.sv */
// Interrupt request and acknowledge carrier between control and arbiter
`timescale 1ns/100ps
interface irq_if;
  logic [7:0] req;
  logic inta;
  logic rti;
  logic clear;
  logic sav;
  logic [7:0] base;
  logic irq_out;
  logic [7:0] vector;
  modport ctl (output req, inta, rti, clear, sav, base, input irq_out, vector);
  modport arb (input req, inta, rti, clear, sav, base, output irq_out, vector);
endinterface

/* File: hw/serial_ctrl_command_interrupt.sv */
// Command decoder, pointer and interrupt control of a two-channel serial controller
`timescale 1ns/100ps
`include "serial_ctrl_defines.svh"
module serial_ctrl_command_interrupt (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Peripheral bus, strobes last one cycle
  input wire logic i_cs,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire serial_ctrl_pkg::port_sel_type i_port,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Interrupt to the CPU
  input wire logic i_inta,
  output logic o_int,
  output logic [7:0] o_vector,
  // Channel conditions, index 0 is channel A
  input wire logic [1:0] i_tx_empty,
  input wire logic [1:0] i_rx_avail,
  input wire logic [1:0] i_rx_char,
  input wire logic [1:0] i_parity_err,
  input wire logic [1:0] i_overrun_err,
  input wire logic [1:0] i_framing_err,
  input wire logic [1:0] i_end_frame,
  input wire logic [1:0] i_dcd,
  input wire logic [1:0] i_cts,
  input wire logic [1:0] i_sync,
  input wire logic [1:0] i_break_abort,
  input wire logic [1:0] i_underrun_eom,
  input wire logic [1:0] i_bit_sync_mode,
  input wire logic [1:0][7:0] i_rx_data,
  // Channel control pulses, with the configuration index and data
  output logic [1:0] o_send_abort,
  output logic [1:0] o_rx_crc_reset,
  output logic [1:0] o_tx_crc_reset,
  output logic [1:0] o_chan_reset,
  output logic [1:0] o_tx_load,
  output logic [1:0] o_rx_take,
  output logic [1:0] o_cfg_write,
  output logic [2:0] o_cfg_index,
  output logic [7:0] o_cfg_data,
  // DMA request to the I/O processor
  output logic o_chan_a_wait_ready_out_n
);
  import serial_ctrl_pkg::*;

  top_state_type s_q, s_d;
  logic ch;
  logic wr_cmd;
  logic rd_cmd;
  logic [1:0] rst_mask;
  logic [1:0] clr_pend;
  logic [1:0][4:0] live;
  logic [1:0][7:0] rr0;
  logic [1:0][7:0] rr1;
  rx_mode_type [1:0] rx_mode;
  logic [1:0] ext_evt;
  logic [1:0] tx_rise;
  logic [1:0] spec_evt;
  cmd_type cmd;
  aux_type aux;

  irq_if irq ();

  // Port decode; upper select bit picks the channel
  assign ch = i_port[1];
  assign wr_cmd = i_cs & i_wr & i_port[0];
  assign rd_cmd = i_cs & i_rd & i_port[0];
  assign cmd = cmd_type'(i_wdata[`CMD_F]);
  assign aux = aux_type'(i_wdata[`AUX_F]);

  // Per-channel condition sensing, status and requests
  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign live[g] = {i_tx_empty[g], i_break_abort[g], i_cts[g], i_sync[g], i_dcd[g]};
    assign rx_mode[g] = rx_mode_type'(s_q.ctrl[g][`CTL_RXM]);

    // Any modem edge, break change or underrun latch setting
    assign ext_evt[g] = (|(live[g][3:0] ^ s_q.prev[g][3:0])) |
      i_underrun_eom[g];
    assign tx_rise[g] = live[g][4] & ~s_q.prev[g][4];

    // Parity drops out in the last mode so the vector stays clean
    assign spec_evt[g] = i_overrun_err[g] | i_framing_err[g] | i_end_frame[g] |
      (i_parity_err[g] & (rx_mode[g] != RXM_ALL));

    // Latched snapshot shown while a status interrupt is held
    assign rr0[g] =
      (8'(i_rx_avail[g]) << `RR0_RX) |
      (8'(i_tx_empty[g]) << `RR0_TXE) |
      (8'(s_q.ext_pend[g] ? s_q.snap[g][0] : i_dcd[g]) << `RR0_DCD) |
      (8'(s_q.ext_pend[g] ? s_q.snap[g][1] : i_sync[g]) << `RR0_SYNC) |
      (8'(s_q.ext_pend[g] ? s_q.snap[g][2] : i_cts[g]) << `RR0_CTS) |
      (8'(s_q.urun[g]) << `RR0_URUN) |
      (8'(s_q.ext_pend[g] ? s_q.snap[g][3] : i_break_abort[g]) << `RR0_BRK);

    assign rr1[g] = (8'(s_q.par_err[g]) << `RR1_PAR) |
      (8'(s_q.ovr_err[g]) << `RR1_OVR);

    // Channel A owns codes 4..7, channel B codes 0..3
    assign irq.req[(1 - g) * 4 + 0] = s_q.ctrl[g][`CTL_TX_EN] & s_q.tx_pend[g];
    assign irq.req[(1 - g) * 4 + 1] = s_q.ctrl[g][`CTL_EXT_EN] & s_q.ext_pend[g];
    assign irq.req[(1 - g) * 4 + 2] = (rx_mode[g] == RXM_FIRST) ? s_q.rx_first[g] :
      ((rx_mode[g] != RXM_OFF) & i_rx_avail[g]);
    assign irq.req[(1 - g) * 4 + 3] = (rx_mode[g] != RXM_OFF) & s_q.spec_pend[g];
  end

  // Commands clear first, channel events set afterwards
  always_comb begin
    s_d = s_q;
    rst_mask = 2'h0;
    clr_pend = 2'h0;
    s_d.abort = 2'h0;
    s_d.rx_crc = 2'h0;
    s_d.tx_crc = 2'h0;
    s_d.chan_rst = 2'h0;
    s_d.tx_load = 2'h0;
    s_d.rx_take = 2'h0;
    s_d.cfg_write = 2'h0;
    irq.rti = 1'b0;

    // Data port traffic
    if (i_cs && i_wr && !i_port[0]) begin
      s_d.tx_load[ch] = 1'b1;
      s_d.cfg_data = i_wdata;
      s_d.tx_pend[ch] = 1'b0;
    end
    if (i_cs && i_rd && !i_port[0]) begin
      s_d.rdata = i_rx_data[ch];
      s_d.rx_take[ch] = 1'b1;
      s_d.rx_first[ch] = 1'b0;
    end

    // Command port write with pointer at zero: command byte
    if (wr_cmd && (s_q.ptr[ch] == `PTR_ZERO)) begin
      s_d.ptr[ch] = i_wdata[`PTR_F];
      case (cmd)
        CMD_ABORT: begin
          s_d.abort[ch] = i_bit_sync_mode[ch];
        end
        CMD_EXT_RST: begin
          s_d.ext_pend[ch] = 1'b0;
        end
        CMD_CHAN_RST: begin
          rst_mask[ch] = 1'b1;
          if (ch == `CH_A) begin
            clr_pend = 2'h3;
          end
        end
        CMD_RX_FIRST: begin
          s_d.rx_armed[ch] = 1'b1;
          s_d.rx_first[ch] = 1'b0;
        end
        CMD_TX_RST: begin
          s_d.tx_pend[ch] = 1'b0;
        end
        CMD_ERR_RST: begin
          s_d.par_err[ch] = 1'b0;
          s_d.ovr_err[ch] = 1'b0;
          s_d.spec_pend[ch] = 1'b0;
        end
        CMD_RTI: begin
          irq.rti = (ch == `CH_A);
        end
        default: begin
        end
      endcase
      case (aux)
        AUX_RX_CRC: begin
          s_d.rx_crc[ch] = 1'b1;
        end
        AUX_TX_CRC: begin
          s_d.tx_crc[ch] = 1'b1;
        end
        AUX_URUN: begin
          s_d.urun[ch] = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Command port write with pointer set: register load
    if (wr_cmd && (s_q.ptr[ch] != `PTR_ZERO)) begin
      case (s_q.ptr[ch])
        `PTR_CTRL: begin
          s_d.ctrl[ch] = i_wdata;
        end
        `PTR_VBASE: begin
          if (ch == `CH_B) begin
            s_d.vbase = i_wdata;
          end
        end
        default: begin
          // Mode, receiver, transmitter and sync registers live elsewhere
          s_d.cfg_write[ch] = 1'b1;
          s_d.cfg_index = s_q.ptr[ch];
          s_d.cfg_data = i_wdata;
        end
      endcase
      s_d.ptr[ch] = `PTR_ZERO;
    end

    // Status read; pointer always falls back to zero
    if (rd_cmd) begin
      case (s_q.ptr[ch])
        `PTR_ZERO: begin
          s_d.rdata = rr0[ch];
        end
        `PTR_CTRL: begin
          s_d.rdata = rr1[ch];
        end
        `PTR_VBASE: begin
          s_d.rdata = (ch == `CH_B) ? irq.vector : 8'h00;
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
      s_d.ptr[ch] = `PTR_ZERO;
    end

    // Channel reset behaves as a hardware reset for its channel; a channel A reset also clears channel B's pending bits
    for (int c = 0; c < 2; c++) begin
      if (rst_mask[c]) begin
        s_d.ptr[c] = `PTR_ZERO;
        s_d.ctrl[c] = `CTRL_RST;
        s_d.rx_armed[c] = 1'b1;
        s_d.par_err[c] = 1'b0;
        s_d.ovr_err[c] = 1'b0;
        s_d.urun[c] = 1'b0;
        s_d.chan_rst[c] = 1'b1;
      end
      if (rst_mask[c] || clr_pend[c]) begin
        s_d.ext_pend[c] = 1'b0;
        s_d.tx_pend[c] = 1'b0;
        s_d.rx_first[c] = 1'b0;
        s_d.spec_pend[c] = 1'b0;
      end
    end

    // Events land after clears, so a same-cycle event survives
    for (int c = 0; c < 2; c++) begin
      s_d.prev[c] = live[c];
      if (ext_evt[c] && s_d.ctrl[c][`CTL_EXT_EN] && !s_d.ext_pend[c]) begin
        s_d.ext_pend[c] = 1'b1;
        s_d.snap[c] = live[c][3:0];
      end
      if (i_underrun_eom[c]) begin
        s_d.urun[c] = 1'b1;
      end
      if (tx_rise[c]) begin
        s_d.tx_pend[c] = 1'b1;
      end
      if (i_rx_char[c] && s_d.rx_armed[c] && (rx_mode[c] == RXM_FIRST)) begin
        s_d.rx_first[c] = 1'b1;
        s_d.rx_armed[c] = 1'b0;
      end
      if (spec_evt[c] && (rx_mode[c] != RXM_OFF)) begin
        s_d.spec_pend[c] = 1'b1;
      end
      if (i_parity_err[c]) begin
        s_d.par_err[c] = 1'b1;
      end
      if (i_overrun_err[c]) begin
        s_d.ovr_err[c] = 1'b1;
      end
    end
  end

  // Single state register
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
      s_q.vbase <= `VBASE_RST;
      s_q.rx_armed <= `RX_ARMED_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Arbiter hookup; vector mode follows channel B control
  assign irq.inta = i_inta;
  assign irq.clear = s_q.chan_rst[`CH_A];
  assign irq.sav = s_q.ctrl[`CH_B][`CTL_SAV];
  assign irq.base = s_q.vbase;

  irq_arbiter u_arb (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .irq(irq)
  );

  // Channel B ready bits go nowhere: only A has the pin
  chan_ready u_ready (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_ctrl(s_q.ctrl[`CH_A][`CTL_RDY]),
    .i_tx_empty(i_tx_empty[`CH_A]),
    .i_rx_avail(i_rx_avail[`CH_A]),
    .o_ready_n(o_chan_a_wait_ready_out_n)
  );

  // Outputs from the state registers; o_int is combined in the arbiter
  assign o_rdata = s_q.rdata;
  assign o_int = irq.irq_out;
  assign o_vector = irq.vector;
  assign o_send_abort = s_q.abort;
  assign o_rx_crc_reset = s_q.rx_crc;
  assign o_tx_crc_reset = s_q.tx_crc;
  assign o_chan_reset = s_q.chan_rst;
  assign o_tx_load = s_q.tx_load;
  assign o_rx_take = s_q.rx_take;
  assign o_cfg_write = s_q.cfg_write;
  assign o_cfg_index = s_q.cfg_index;
  assign o_cfg_data = s_q.cfg_data;
endmodule

/* File: hw/serial_ctrl_defines.svh */
// Offsets, field positions, reset values and codes of the command block
`ifndef SERIAL_CTRL_DEFINES_SVH
`define SERIAL_CTRL_DEFINES_SVH
// Peripheral port select codes
`define PORT_DATA_A 2'h0
`define PORT_CMD_A 2'h1
`define PORT_DATA_B 2'h2
`define PORT_CMD_B 2'h3
// Channel indices
`define CH_A 1'b0
`define CH_B 1'b1
// Command byte fields
`define PTR_F 2:0
`define CMD_F 5:3
`define AUX_F 7:6
// Register pointer values
`define PTR_ZERO 3'h0
`define PTR_CTRL 3'h1
`define PTR_VBASE 3'h2
// Interrupt and ready control fields
`define CTL_EXT_EN 0
`define CTL_TX_EN 1
`define CTL_SAV 2
`define CTL_RXM 4:3
`define CTL_RDY 7:5
// Ready sub-field positions
`define RDY_ONRX 0
`define RDY_FUNC 1
`define RDY_EN 2
// Primary status bits
`define RR0_RX 0
`define RR0_TXE 2
`define RR0_DCD 3
`define RR0_SYNC 4
`define RR0_CTS 5
`define RR0_URUN 6
`define RR0_BRK 7
// Receive error status bits
`define RR1_PAR 4
`define RR1_OVR 5
// Condition code field inside the vector
`define VEC_CODE 3:1
// Reset values
`define CTRL_RST 8'h00
`define VBASE_RST 8'h00
`define RX_ARMED_RST 2'h3
`define READY_RST 1'b1
`endif

/* File: hw/serial_ctrl_pkg.sv */
// Types shared by the command and interrupt block
package serial_ctrl_pkg;
  typedef logic [1:0] port_sel_type;
  typedef enum logic [2:0] {
    CMD_NULL = 3'h0, CMD_ABORT = 3'h1, CMD_EXT_RST = 3'h2, CMD_CHAN_RST = 3'h3,
    CMD_RX_FIRST = 3'h4, CMD_TX_RST = 3'h5, CMD_ERR_RST = 3'h6, CMD_RTI = 3'h7
  } cmd_type;
  typedef enum logic [1:0] {
    AUX_NULL = 2'h0, AUX_RX_CRC = 2'h1, AUX_TX_CRC = 2'h2, AUX_URUN = 2'h3
  } aux_type;
  typedef enum logic [1:0] {
    RXM_OFF = 2'h0, RXM_FIRST = 2'h1, RXM_ALL_PAR = 2'h2, RXM_ALL = 2'h3
  } rx_mode_type;
  typedef enum logic [1:0] {
    SRC_TX = 2'h0, SRC_EXT = 2'h1, SRC_RX = 2'h2, SRC_SPEC = 2'h3
  } src_type;
  typedef struct packed {
    logic [1:0][2:0] ptr;
    logic [1:0][7:0] ctrl;
    logic [7:0] vbase;
    logic [1:0] ext_pend;
    logic [1:0] tx_pend;
    logic [1:0] rx_armed;
    logic [1:0] rx_first;
    logic [1:0] spec_pend;
    logic [1:0] par_err;
    logic [1:0] ovr_err;
    logic [1:0] urun;
    logic [1:0][4:0] prev;
    logic [1:0][3:0] snap;
    logic [7:0] rdata;
    logic [7:0] cfg_data;
    logic [2:0] cfg_index;
    logic [1:0] abort;
    logic [1:0] rx_crc;
    logic [1:0] tx_crc;
    logic [1:0] chan_rst;
    logic [1:0] tx_load;
    logic [1:0] rx_take;
    logic [1:0] cfg_write;
  } top_state_type;
  typedef struct packed {
    logic in_service;
    logic [7:0] vector;
  } arb_state_type;
  typedef struct packed {
    logic ready_n;
  } ready_state_type;
endpackage

/* File: test/host_ack_model.sv */
// Host processor acknowledging interrupts after a set delay
`timescale 1ns/100ps
module host_ack_model #(
  parameter int DELAY = 2
) (
  // Clock and control
  input wire logic i_mclk,
  input wire logic i_en,
  input wire logic i_int,
  // Acknowledge pulse
  output logic o_inta
);
  int cnt;
  initial begin
    o_inta = 1'b0;
    cnt = 0;
  end
  // One-cycle acknowledge, repeated after the delay while the interrupt stays raised
  always @(posedge i_mclk) begin
    if (o_inta || !i_en || !i_int) begin
      o_inta <= 1'b0;
      cnt <= 0;
    end else if (cnt == DELAY) begin
      o_inta <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

/* File: test/serial_ctrl_asserts.sv */
// Concurrent checks on the ports of the command and interrupt block
`timescale 1ns/100ps
module serial_ctrl_asserts (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Bus and channel inputs
  input wire logic i_cs,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire serial_ctrl_pkg::port_sel_type i_port,
  input wire logic [7:0] i_wdata,
  input wire logic i_inta,
  input wire logic [1:0] i_tx_empty,
  input wire logic [1:0] i_rx_avail,
  input wire logic [1:0] i_bit_sync_mode,
  // Outputs under watch
  input wire logic o_int,
  input wire logic [1:0] o_send_abort,
  input wire logic [1:0] o_chan_reset,
  input wire logic [1:0] o_rx_crc_reset,
  input wire logic [1:0] o_tx_crc_reset,
  input wire logic [1:0] o_tx_load,
  input wire logic [1:0] o_rx_take,
  input wire logic o_chan_a_wait_ready_out_n
);
  import serial_ctrl_pkg::*;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Abort and tx load pulses on A, reset, crc and rx take pulses on B need a matching access on the previous edge
  abort_cause_a: assert property (o_send_abort[0] |-> $past(i_cs && i_wr && i_port == 2'h1
    && i_wdata[5:3] == 3'h1 && i_bit_sync_mode[0])) else $error("abort pulse without command");
  chan_rst_cause_a: assert property (o_chan_reset[1] |-> $past(i_cs && i_wr
    && i_port == 2'h3 && i_wdata[5:3] == 3'h3)) else $error("channel reset without command");
  rx_crc_cause_a: assert property (o_rx_crc_reset[1] |-> $past(i_cs && i_wr
    && i_port == 2'h3 && i_wdata[7:6] == 2'h1)) else $error("rx crc reset without command");
  tx_crc_cause_a: assert property (o_tx_crc_reset[1] |-> $past(i_cs && i_wr
    && i_port == 2'h3 && i_wdata[7:6] == 2'h2)) else $error("tx crc reset without command");
  tx_load_cause_a: assert property (o_tx_load[0] |-> $past(i_cs && i_wr && i_port == 2'h0))
    else $error("tx load without data write");
  rx_take_cause_a: assert property (o_rx_take[1] |-> $past(i_cs && i_rd && i_port == 2'h2))
    else $error("rx take without data read");
  // Acknowledge moves the request into service at once
  int_ack_drop_a: assert property (i_inta && o_int |=> !o_int)
    else $error("interrupt still raised after acknowledge");
  chan_a_rst_a: assert property (o_chan_reset[0] |-> !o_int)
    else $error("interrupt survives channel A reset");
  // Request only follows a buffer condition
  ready_cause_a: assert property ($fell(o_chan_a_wait_ready_out_n) |->
    $past(i_tx_empty[0]) || $past(i_rx_avail[0])) else $error("ready low without cause");
endmodule
bind serial_ctrl_command_interrupt serial_ctrl_asserts serial_ctrl_asserts_i (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cs(i_cs), .i_wr(i_wr), .i_rd(i_rd),
  .i_port(i_port), .i_wdata(i_wdata), .i_inta(i_inta), .i_tx_empty(i_tx_empty),
  .i_rx_avail(i_rx_avail), .i_bit_sync_mode(i_bit_sync_mode), .o_int(o_int),
  .o_send_abort(o_send_abort), .o_chan_reset(o_chan_reset), .o_rx_crc_reset(o_rx_crc_reset),
  .o_tx_crc_reset(o_tx_crc_reset), .o_tx_load(o_tx_load), .o_rx_take(o_rx_take),
  .o_chan_a_wait_ready_out_n(o_chan_a_wait_ready_out_n));

/* File: test/testbench.sv */
// Self-checking bench for the command and interrupt block
`timescale 1ns/100ps
module testbench;
  import serial_ctrl_pkg::*;
  logic i_mclk, i_reset_n, i_cs, i_rd, i_wr, i_inta, o_int, ready_n, ack_en;
  port_sel_type i_port;
  logic [7:0] i_wdata, o_rdata, o_vector, o_cfg_data;
  logic [2:0] o_cfg_index;
  logic [1:0] tx_empty, rx_avail, rx_char, par_err, ovr_err, dcd, bsync, cts, urun;
  logic [1:0] abort, rx_crc, tx_crc, chan_rst, tx_load, rx_take, cfg_wr;
  logic [1:0][7:0] rx_data;
  int fail_count, n_compared, cycles;
  serial_ctrl_command_interrupt serial_ctrl_command_interrupt_i (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_cs(i_cs), .i_rd(i_rd), .i_wr(i_wr), .i_port(i_port),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_inta(i_inta), .o_int(o_int), .o_vector(o_vector),
    .i_tx_empty(tx_empty), .i_rx_avail(rx_avail), .i_rx_char(rx_char), .i_parity_err(par_err),
    .i_overrun_err(ovr_err), .i_framing_err(2'h0), .i_end_frame(2'h0), .i_dcd(dcd),
    .i_cts(cts), .i_sync(2'h0), .i_break_abort(2'h0), .i_underrun_eom(urun),
    .i_bit_sync_mode(bsync), .i_rx_data(rx_data), .o_send_abort(abort),
    .o_rx_crc_reset(rx_crc), .o_tx_crc_reset(tx_crc), .o_chan_reset(chan_rst),
    .o_tx_load(tx_load), .o_rx_take(rx_take), .o_cfg_write(cfg_wr), .o_cfg_index(o_cfg_index),
    .o_cfg_data(o_cfg_data), .o_chan_a_wait_ready_out_n(ready_n));
  host_ack_model #(.DELAY(3)) host_ack_model_i (.i_mclk(i_mclk), .i_en(ack_en), .i_int(o_int),
    .o_inta(i_inta));
  // Wide enough for a pulse vector beside a data byte
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bus access: strobes for one cycle, taken at the second edge
  task access(input logic rd, input port_sel_type p, input logic [7:0] d);
    @(posedge i_mclk);
    i_cs <= 1'b1;
    i_rd <= rd;
    i_wr <= !rd;
    i_port <= p;
    i_wdata <= d;
    @(posedge i_mclk);
    i_cs <= 1'b0;
    i_rd <= 1'b0;
    i_wr <= 1'b0;
    #1;
  endtask
  task wr(input port_sel_type p, input logic [7:0] d);
    access(1'b0, p, d);
  endtask
  task rd(input port_sel_type p, input logic [7:0] exp);
    access(1'b1, p, 8'h00);
    check(o_rdata, exp);
  endtask
  // Bounded wait on the interrupt line
  task wait_int(input logic v);
    int n;
    for (n = 0; n < 50 && o_int !== v; n++) begin
      @(posedge i_mclk);
      #1;
    end
    check({7'h0, o_int}, {7'h0, v});
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Hang guard, far above the few hundred cycles the tests take
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict;
    end
  end
  initial begin
    {i_reset_n, i_cs, i_rd, i_wr, ack_en, i_port, i_wdata} = '0;
    {tx_empty, rx_avail, rx_char, par_err, ovr_err, dcd, cts, urun} = '0;
    bsync = 2'b10;
    rx_data = {8'h3c, 8'h00};
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    #1;
    check({o_int, ready_n, 6'h0}, 8'h40);
    check(o_vector, 8'h00);
    rd(2'h1, 8'h00);
    $display("reset test done");
    // Mode register first, then the rest of the channel A registers
    for (int j = 0; j < 5; j++) begin
      wr(2'h1, 8'((j + 1) % 5 + 3));
      wr(2'h1, 8'((j + 1) % 5 + 83));
      check({cfg_wr, o_cfg_index, 3'h0}, {2'h1, 3'((j + 1) % 5 + 3), 3'h0});
      check(o_cfg_data, 8'((j + 1) % 5 + 83));
    end
    wr(2'h1, 8'h00);
    check({6'h0, cfg_wr}, 8'h00);
    wr(2'h1, 8'h08);
    check({6'h0, abort}, 8'h00);
    $display("pointer test done");
    // Every command and auxiliary code on channel B
    for (int k = 0; k < 8; k++) begin
      wr(2'h3, {2'(k), 3'(k), 3'h0});
      check({abort[1], chan_rst, rx_crc[1], tx_crc[1], 3'h0},
        {k == 1, k == 3, 1'b0, k % 4 == 1, k % 4 == 2, 3'h0});
    end
    wr(2'h3, 8'h04);
    wr(2'h3, 8'h44);
    wr(2'h3, 8'h02);
    wr(2'h3, 8'ha0);
    wr(2'h1, 8'h02);
    wr(2'h1, 8'hff);
    wr(2'h3, 8'h02);
    rd(2'h3, 8'ha0);
    $display("command test done");
    // Parity error stays latched until error reset
    @(posedge i_mclk);
    par_err[0] <= 1'b1;
    @(posedge i_mclk);
    par_err[0] <= 1'b0;
    wr(2'h1, 8'h01);
    rd(2'h1, 8'h10);
    rd(2'h1, 8'h00);
    wr(2'h1, 8'h30);
    wr(2'h1, 8'h01);
    rd(2'h1, 8'h00);
    // Carrier change is held until the external reset command
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h01);
    @(posedge i_mclk);
    dcd[0] <= 1'b1;
    wait_int(1'b1);
    @(posedge i_mclk);
    dcd[0] <= 1'b0;
    rd(2'h1, 8'h08);
    wr(2'h1, 8'h10);
    rd(2'h1, 8'h00);
    // Modem and underrun events share one latch with a snapshot
    @(posedge i_mclk);
    cts[0] <= 1'b1;
    wait_int(1'b1);
    rd(2'h1, 8'h20);
    wr(2'h1, 8'h10);
    check({7'h0, o_int}, 8'h00);
    @(posedge i_mclk);
    urun[0] <= 1'b1;
    @(posedge i_mclk);
    urun[0] <= 1'b0;
    wait_int(1'b1);
    rd(2'h1, 8'h60);
    wr(2'h1, 8'hd0);
    rd(2'h1, 8'h20);
    // Masked first, so dropping the line raises nothing
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h00);
    @(posedge i_mclk);
    cts[0] <= 1'b0;
    // First-character mode: one interrupt, silent until rearmed
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h08);
    for (int m = 0; m < 3; m++) begin
      @(posedge i_mclk);
      rx_char[0] <= 1'b1;
      @(posedge i_mclk);
      rx_char[0] <= 1'b0;
      repeat (2) @(posedge i_mclk);
      #1;
      check({7'h0, o_int}, {7'h0, m != 1});
      rd(2'h0, 8'h00);
      if (m == 1) begin
        wr(2'h1, 8'h20);
      end
    end
    // Parity ignored in the last mode, overrun still special
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h18);
    @(posedge i_mclk);
    par_err[0] <= 1'b1;
    @(posedge i_mclk);
    par_err[0] <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    check({7'h0, o_int}, 8'h00);
    @(posedge i_mclk);
    ovr_err[0] <= 1'b1;
    @(posedge i_mclk);
    ovr_err[0] <= 1'b0;
    wait_int(1'b1);
    wr(2'h1, 8'h30);
    check({7'h0, o_int}, 8'h00);
    // Parity counts in the third mode, and so does a waiting character
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h10);
    @(posedge i_mclk);
    par_err[0] <= 1'b1;
    @(posedge i_mclk);
    par_err[0] <= 1'b0;
    wait_int(1'b1);
    wr(2'h1, 8'h30);
    @(posedge i_mclk);
    rx_avail[0] <= 1'b1;
    wait_int(1'b1);
    @(posedge i_mclk);
    rx_avail[0] <= 1'b0;
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h00);
    $display("status test done");
    // Transmit interrupt with status-modified vector
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h02);
    wr(2'h3, 8'h01);
    wr(2'h3, 8'h04);
    ack_en <= 1'b1;
    @(posedge i_mclk);
    tx_empty[0] <= 1'b1;
    wait_int(1'b1);
    wait_int(1'b0);
    check(o_vector, 8'ha8);
    ack_en <= 1'b0;
    wr(2'h3, 8'h38);
    check({7'h0, o_int}, 8'h00);
    wr(2'h1, 8'h38);
    check({7'h0, o_int}, 8'h01);
    wr(2'h1, 8'h28);
    check({7'h0, o_int}, 8'h00);
    wr(2'h0, 8'h55);
    check({tx_load, o_cfg_data}, {2'h1, 8'h55});
    rd(2'h2, 8'h3c);
    check({6'h0, rx_take}, 8'h02);
    $display("vector test done");
    // Channel A reset drops a pending request
    @(posedge i_mclk);
    tx_empty[0] <= 1'b0;
    @(posedge i_mclk);
    tx_empty[0] <= 1'b1;
    wait_int(1'b1);
    wr(2'h1, 8'h18);
    check({6'h0, o_int, chan_rst[0]}, 8'h01);
    // Ready follows channel A control only
    wr(2'h1, 8'h04);
    wr(2'h1, 8'h44);
    wr(2'h3, 8'h01);
    wr(2'h3, 8'he0);
    @(posedge i_mclk);
    tx_empty <= 2'b11;
    repeat (2) @(posedge i_mclk);
    #1;
    check({7'h0, ready_n}, 8'h01);
    wr(2'h1, 8'h01);
    wr(2'h1, 8'hc0);
    repeat (2) @(posedge i_mclk);
    #1;
    check({7'h0, ready_n}, 8'h00);
    $display("reset and ready test done");
    print_verdict;
  end
endmodule
